//--- hw/srlm_defs.vh
// Constants for the switch reset and lane map block.
// Assumes inclusion by bare name from hw/ sources.
`ifndef SRLM_DEFS_VH
`define SRLM_DEFS_VH

// ----------------------------------------
// Lane positions
// ----------------------------------------
`define SRLM_UP_LANE0_IDX 0
`define SRLM_DN1_LANE_IDX 1
`define SRLM_DN2_LANE_IDX 2
`define SRLM_UP_LANE1_IDX 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRLM_STRAP_RST 1'h1
`define SRLM_HOLD_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRLM_CLK_MHZ 20
`define SRLM_HOTPLUG_RST_US 1
`define SRLM_HOTPLUG_RST_CYC (`SRLM_HOTPLUG_RST_US * `SRLM_CLK_MHZ)

`endif

//--- hw/srlm_port_hold.v
// One downstream port's hot-plug reset stretcher.
// Assumes presence input already synchronised to ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "srlm_defs.vh"

module srlm_port_hold #(
	parameter HOLD_CYC = `SRLM_HOTPLUG_RST_CYC
) (
	// Clock and reset
	input wire ref_clk_in,
	input wire nrst_in,
	// Presence, low when a card sits in the slot
	input wire present_n_in,
	// Reset request to the port
	output wire hold_out
);

	reg was_present_reg;
	reg [7:0] cnt_reg;
	reg [7:0] cnt_next;
	wire insert;

	assign insert = ~present_n_in & ~was_present_reg;

	always @* begin
		cnt_next = cnt_reg;
		if (insert) begin
			// The insert cycle is the first held cycle; HOLD_CYC must be at least 1
			cnt_next = HOLD_CYC[7:0] - 8'h01;
		end else if (cnt_reg != 8'h00) begin
			cnt_next = cnt_reg - 8'h01;
		end
	end

	// Start as absent so a card present at reset release still gets a pulse
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			was_present_reg <= 1'b0;
			cnt_reg <= `SRLM_HOLD_RST;
		end else begin
			was_present_reg <= ~present_n_in;
			cnt_reg <= cnt_next;
		end
	end

	// Insert term closes the gap in which a card seated at reset release would see a release
	assign hold_out = (cnt_reg != 8'h00) | insert;

endmodule
`default_nettype wire

//--- hw/srlm_top.v
// Reset distribution, lane map and clock fan-out strap for a 3-port switch.
// Assumes pins arrive asynchronous; lanes are digital stand-ins of serial pairs.
`timescale 1ns/10ps
`default_nettype none
`include "srlm_defs.vh"

// What this block does
// [RULE_01] While fundamental reset is low, all non-sticky state returns to initial values.
// [RULE_02] Each downstream reset output is asserted whenever fundamental reset is asserted.
// [RULE_03] A downstream reset also asserts when a card is just plugged into that port.
// [RULE_04] Strap high disables clock fan-out buffer and outputs; low enables them.
// [RULE_05] An unconnected strap reads low, so fan-out is enabled by default.
// [RULE_06] Serial lane 0 is upstream lane 0; serial lane 3 is upstream lane 1.
// [RULE_07] Serial lane 1 feeds downstream port 1, lane 2 feeds downstream port 2.
// [RULE_08] When enabled, one reference input fans out to three reference outputs.
// [RULE_09] Strap is sampled during fundamental reset and held until the next reset.
module srlm_top #(
	parameter NUM_DN = 2,
	parameter NUM_REFOUT = 3,
	parameter HOLD_CYC = `SRLM_HOTPLUG_RST_CYC
) (
	// Clock and chip reset
	input wire ref_clk_in,
	input wire nrst_in,
	// Fundamental reset pin, active low
	input wire fundamental_rst_n_in,
	// Presence per downstream port, active low
	input wire [NUM_DN-1:0] slot_present_n_in,
	// Clock fan-out strap, high powers the buffer down
	input wire refclk_fanout_powerdown_in,
	// Reference clock in and fan-out
	input wire refclk_fanout_in_pos_in,
	input wire refclk_fanout_in_neg_in,
	output wire [NUM_REFOUT-1:0] refclk_fanout_out_pos_out,
	output wire [NUM_REFOUT-1:0] refclk_fanout_out_neg_out,
	output wire refclk_fanout_en_out,
	// Serial lanes, pin side
	input wire [3:0] serial_rx_pos_in,
	input wire [3:0] serial_rx_neg_in,
	output reg [3:0] serial_tx_pos_out,
	output reg [3:0] serial_tx_neg_out,
	// Upstream port, two lanes
	output reg [1:0] up_rx_pos_out,
	output reg [1:0] up_rx_neg_out,
	input wire [1:0] up_tx_pos_in,
	input wire [1:0] up_tx_neg_in,
	// Downstream ports, one lane each
	output reg [NUM_DN-1:0] dn_rx_pos_out,
	output reg [NUM_DN-1:0] dn_rx_neg_out,
	input wire [NUM_DN-1:0] dn_tx_pos_in,
	input wire [NUM_DN-1:0] dn_tx_neg_in,
	// Resets
	output reg [NUM_DN-1:0] port_downstream_rst_n_out,
	output wire core_rst_n_out
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [1:0] frst_sync_reg;
	reg [NUM_DN-1:0] prs_meta_reg;
	reg [NUM_DN-1:0] prs_sync_reg;
	reg pd_meta_reg;
	reg pd_sync_reg;
	reg [3:0] rxp_meta_reg;
	reg [3:0] rxn_meta_reg;
	reg [3:0] rxp_sync_reg;
	reg [3:0] rxn_sync_reg;

	// Both edges of the fundamental reset pass two flops; a pin glitch sampled at an edge still passes through
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			frst_sync_reg <= 2'h0;
		end else begin
			frst_sync_reg <= {frst_sync_reg[0], fundamental_rst_n_in};
		end
	end

	// Presence flops reset to absent, so no slot looks occupied before sampling
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prs_meta_reg <= {NUM_DN{1'b1}};
			prs_sync_reg <= {NUM_DN{1'b1}};
		end else begin
			prs_meta_reg <= slot_present_n_in;
			prs_sync_reg <= prs_meta_reg;
		end
	end

	// Strap flops reset low, the level the pull-down gives an open pin
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pd_meta_reg <= 1'b0;
			pd_sync_reg <= 1'b0;
		end else begin
			pd_meta_reg <= refclk_fanout_powerdown_in;
			pd_sync_reg <= pd_meta_reg;
		end
	end

	// Lane samples; two flops of latency are the price of an asynchronous pin
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rxp_meta_reg <= 4'h0;
			rxn_meta_reg <= 4'h0;
			rxp_sync_reg <= 4'h0;
			rxn_sync_reg <= 4'h0;
		end else begin
			rxp_meta_reg <= serial_rx_pos_in;
			rxn_meta_reg <= serial_rx_neg_in;
			rxp_sync_reg <= rxp_meta_reg;
			rxn_sync_reg <= rxn_meta_reg;
		end
	end

	wire frst_n;
	assign frst_n = frst_sync_reg[1];
	// Combined reset for the non-sticky core state
	assign core_rst_n_out = frst_n; // [RULE_01]

	// ----------------------------------------
	// Clock fan-out strap
	// ----------------------------------------
	// Sticky-like: tracks only while fundamental reset holds, then freezes.
	// Chip reset value enables the buffer, as the pin pull-down would.
	reg pd_hold_reg;
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pd_hold_reg <= ~`SRLM_STRAP_RST; // [RULE_05]
		end else if (!frst_n) begin
			pd_hold_reg <= pd_sync_reg; // [RULE_09]
		end
	end

	assign refclk_fanout_en_out = ~pd_hold_reg; // [RULE_04]

	// Clock path is a gated buffer; it cannot go through flops at this rate
	assign refclk_fanout_out_pos_out =
		{NUM_REFOUT{refclk_fanout_in_pos_in & refclk_fanout_en_out}}; // [RULE_08]
	assign refclk_fanout_out_neg_out =
		{NUM_REFOUT{refclk_fanout_in_neg_in & refclk_fanout_en_out}}; // [RULE_08]

	// ----------------------------------------
	// Downstream resets
	// ----------------------------------------
	wire [NUM_DN-1:0] hold;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_DN; gi = gi + 1) begin : g_port
			srlm_port_hold #(
				.HOLD_CYC(HOLD_CYC)
			) u_hold (
				.ref_clk_in(ref_clk_in),
				.nrst_in(frst_n),
				.present_n_in(prs_sync_reg[gi]),
				.hold_out(hold[gi])
			); // [RULE_03]
		end
	endgenerate

	// Fundamental reset or a hot-plug hold pulls a port's reset low
	reg [NUM_DN-1:0] dn_rst_n_next;
	always @* begin
		dn_rst_n_next = {NUM_DN{frst_n}} & ~hold; // [RULE_02] [RULE_03]
	end

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			port_downstream_rst_n_out <= {NUM_DN{1'b0}};
		end else begin
			port_downstream_rst_n_out <= dn_rst_n_next;
		end
	end

	// ----------------------------------------
	// Lane map
	// ----------------------------------------
	reg [1:0] up_rx_pos_next;
	reg [1:0] up_rx_neg_next;
	reg [NUM_DN-1:0] dn_rx_pos_next;
	reg [NUM_DN-1:0] dn_rx_neg_next;
	reg [3:0] serial_tx_pos_next;
	reg [3:0] serial_tx_neg_next;

	// Lanes read as idle zero while the fundamental reset is seen
	always @* begin
		up_rx_pos_next = 2'h0; // [RULE_01]
		up_rx_neg_next = 2'h0;
		dn_rx_pos_next = {NUM_DN{1'b0}};
		dn_rx_neg_next = {NUM_DN{1'b0}};
		serial_tx_pos_next = 4'h0;
		serial_tx_neg_next = 4'h0;
		if (frst_n) begin
			up_rx_pos_next[0] = rxp_sync_reg[`SRLM_UP_LANE0_IDX]; // [RULE_06]
			up_rx_neg_next[0] = rxn_sync_reg[`SRLM_UP_LANE0_IDX];
			up_rx_pos_next[1] = rxp_sync_reg[`SRLM_UP_LANE1_IDX]; // [RULE_06]
			up_rx_neg_next[1] = rxn_sync_reg[`SRLM_UP_LANE1_IDX];
			dn_rx_pos_next[0] = rxp_sync_reg[`SRLM_DN1_LANE_IDX]; // [RULE_07]
			dn_rx_neg_next[0] = rxn_sync_reg[`SRLM_DN1_LANE_IDX];
			dn_rx_pos_next[1] = rxp_sync_reg[`SRLM_DN2_LANE_IDX]; // [RULE_07]
			dn_rx_neg_next[1] = rxn_sync_reg[`SRLM_DN2_LANE_IDX];
			serial_tx_pos_next[`SRLM_UP_LANE0_IDX] = up_tx_pos_in[0]; // [RULE_06]
			serial_tx_neg_next[`SRLM_UP_LANE0_IDX] = up_tx_neg_in[0];
			serial_tx_pos_next[`SRLM_UP_LANE1_IDX] = up_tx_pos_in[1];
			serial_tx_neg_next[`SRLM_UP_LANE1_IDX] = up_tx_neg_in[1];
			serial_tx_pos_next[`SRLM_DN1_LANE_IDX] = dn_tx_pos_in[0]; // [RULE_07]
			serial_tx_neg_next[`SRLM_DN1_LANE_IDX] = dn_tx_neg_in[0];
			serial_tx_pos_next[`SRLM_DN2_LANE_IDX] = dn_tx_pos_in[1];
			serial_tx_neg_next[`SRLM_DN2_LANE_IDX] = dn_tx_neg_in[1];
		end
	end

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			up_rx_pos_out <= 2'h0;
			up_rx_neg_out <= 2'h0;
			dn_rx_pos_out <= {NUM_DN{1'b0}};
			dn_rx_neg_out <= {NUM_DN{1'b0}};
			serial_tx_pos_out <= 4'h0;
			serial_tx_neg_out <= 4'h0;
		end else begin
			up_rx_pos_out <= up_rx_pos_next;
			up_rx_neg_out <= up_rx_neg_next;
			dn_rx_pos_out <= dn_rx_pos_next;
			dn_rx_neg_out <= dn_rx_neg_next;
			serial_tx_pos_out <= serial_tx_pos_next;
			serial_tx_neg_out <= serial_tx_neg_next;
		end
	end

endmodule
`default_nettype wire

//--- tb/srlm_top_asserts.sv
// Port timing checks for srlm_top.
// Assumes bind into srlm_top; only the positive lane legs are watched.
`timescale 1ns/10ps
`default_nettype none
module srlm_top_chk #(parameter NUM_DN = 2, parameter NUM_REFOUT = 3, parameter HOLD_CYC = 20) (
	input wire ref_clk_in,
	input wire nrst_in,
	input wire fundamental_rst_n_in,
	input wire [NUM_DN-1:0] slot_present_n_in,
	input wire refclk_fanout_powerdown_in,
	input wire refclk_fanout_in_pos_in,
	input wire [NUM_REFOUT-1:0] refclk_fanout_out_pos_out,
	input wire refclk_fanout_en_out,
	input wire [3:0] serial_rx_pos_in,
	input wire [3:0] serial_tx_pos_out,
	input wire [1:0] up_rx_pos_out,
	input wire [1:0] up_tx_pos_in,
	input wire [NUM_DN-1:0] dn_rx_pos_out,
	input wire [NUM_DN-1:0] dn_tx_pos_in,
	input wire [NUM_DN-1:0] port_downstream_rst_n_out,
	input wire core_rst_n_out
);
	wire c = core_rst_n_out;
	wire f = fundamental_rst_n_in;
	wire [3:0] rx = serial_rx_pos_in;
	wire [3:0] tx = serial_tx_pos_out;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	AST_UP_RX: assert property (c[*4] |-> up_rx_pos_out == {$past(rx[3], 3), $past(rx[0], 3)})
		else $error("up rx map");
	AST_UP_TX: assert property (c[*3] |-> {tx[3], tx[0]} == $past(up_tx_pos_in))
		else $error("up tx map");
	AST_DN_RX: assert property (c[*4] |-> dn_rx_pos_out == {$past(rx[2], 3), $past(rx[1], 3)})
		else $error("dn rx map");
	AST_DN_TX: assert property (c[*3] |-> tx[2:1] == $past(dn_tx_pos_in))
		else $error("dn tx map");
	AST_DN_RST: assert property ((!f)[*4] |-> !(|port_downstream_rst_n_out))
		else $error("dn rst");
	AST_HOTPLUG: assert property (c && $fell(slot_present_n_in[0]) |-> ##[1:5] !port_downstream_rst_n_out[0])
		else $error("hot plug");
	AST_FANOUT: assert property (refclk_fanout_out_pos_out == {NUM_REFOUT{refclk_fanout_in_pos_in & refclk_fanout_en_out}})
		else $error("fanout");
	AST_STRAP_ON: assert property ((!f && !refclk_fanout_powerdown_in)[*5] |-> refclk_fanout_en_out)
		else $error("strap on");
	AST_STRAP_OFF: assert property ((!f && refclk_fanout_powerdown_in)[*5] |-> !refclk_fanout_en_out)
		else $error("strap off");
	AST_STRAP_HOLD: assert property (c && $past(c) |-> $stable(refclk_fanout_en_out))
		else $error("strap hold");
endmodule
bind srlm_top srlm_top_chk #(.NUM_DN(NUM_DN), .NUM_REFOUT(NUM_REFOUT), .HOLD_CYC(HOLD_CYC)) u_chk (
	.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .fundamental_rst_n_in(fundamental_rst_n_in),
	.slot_present_n_in(slot_present_n_in), .refclk_fanout_en_out(refclk_fanout_en_out),
	.refclk_fanout_powerdown_in(refclk_fanout_powerdown_in),
	.refclk_fanout_in_pos_in(refclk_fanout_in_pos_in),
	.refclk_fanout_out_pos_out(refclk_fanout_out_pos_out),
	.serial_rx_pos_in(serial_rx_pos_in), .serial_tx_pos_out(serial_tx_pos_out),
	.up_rx_pos_out(up_rx_pos_out), .up_tx_pos_in(up_tx_pos_in), .dn_rx_pos_out(dn_rx_pos_out),
	.dn_tx_pos_in(dn_tx_pos_in), .core_rst_n_out(core_rst_n_out),
	.port_downstream_rst_n_out(port_downstream_rst_n_out)
);
`default_nettype wire

//--- tb/srlm_far_model.sv
// Far-side lane driver for the upstream host and the downstream cards.
// Assumes lane data is presented at the rising edge; the bench forms the negative legs.
`timescale 1ns/10ps
`default_nettype none
module srlm_far_model (
	input wire logic ref_clk_in,
	input wire logic [3:0] lane_data_in,
	output var logic [3:0] rx_pos_out
);
	// Launched on the edge, like a real transmitter, so the switch sees a full cycle
	always @(posedge ref_clk_in) begin
		rx_pos_out <= lane_data_in;
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for srlm_top: strap, lane map, downstream resets.
// Assumes a 20 MHz clock and a short hot-plug hold.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam HOLD = 4;
	logic ref_clk_in = 1'b0, nrst_in = 1'b0, frst = 1'b0, pd = 1'b0, rin = 1'b1, en, crst;
	logic [1:0] pres = 2'h3, utx = 2'h0, dtx = 2'h0, urx, drx, dnr, urn, drn;
	logic [3:0] ld = 4'h0, rxp, txp, txn;
	logic [2:0] rop, ron;
	integer n_errors = 0, samples_checked = 0, seed = 31476, i, r;
	srlm_top #(.HOLD_CYC(HOLD)) DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
		.fundamental_rst_n_in(frst), .slot_present_n_in(pres), .refclk_fanout_powerdown_in(pd),
		.refclk_fanout_in_pos_in(rin), .refclk_fanout_in_neg_in(~rin), .refclk_fanout_en_out(en),
		.refclk_fanout_out_pos_out(rop), .refclk_fanout_out_neg_out(ron), .serial_rx_pos_in(rxp),
		.serial_rx_neg_in(~rxp), .serial_tx_pos_out(txp), .serial_tx_neg_out(txn),
		.up_rx_pos_out(urx), .up_rx_neg_out(urn), .up_tx_pos_in(utx), .up_tx_neg_in(~utx),
		.dn_rx_pos_out(drx), .dn_rx_neg_out(drn), .dn_tx_pos_in(dtx), .dn_tx_neg_in(~dtx),
		.port_downstream_rst_n_out(dnr), .core_rst_n_out(crst));
	srlm_far_model FAR (.ref_clk_in(ref_clk_in), .lane_data_in(ld), .rx_pos_out(rxp));
	function automatic logic [3:0] rxmap(input logic [3:0] l);
		return {l[2], l[1], l[3], l[0]};
	endfunction
	function automatic logic [3:0] txmap(input logic [1:0] u, input logic [1:0] d);
		return {u[1], d[1], d[0], u[0]};
	endfunction
	task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// Call just after the edge that starts a hold; checks its first and last low cycle
	task automatic hold_chk(input logic [3:0] lowv);
		cyc(3);
		@(negedge ref_clk_in);
		chk("hold start", dnr, lowv);
		cyc(HOLD - 1);
		@(negedge ref_clk_in);
		chk("hold last", dnr, lowv);
		cyc(1);
		@(negedge ref_clk_in);
		chk("hold end", dnr, 4'h3);
	endtask
	initial forever #25 ref_clk_in = ~ref_clk_in;
	// About 1270 cycles are needed; 4000 leaves margin
	initial begin
		#200000;
		n_errors++;
		stop_test;
	end
	initial begin
		cyc(3);
		@(negedge ref_clk_in);
		chk("strap default", en, 4'h1);
		chk("dn rst chip", dnr, 4'h0);
		cyc(1);
		nrst_in <= 1'b1;
		for (i = 0; i < 2; i++) begin
			cyc(1);
			pd <= ~i[0];
			frst <= 1'b0;
			cyc(8);
			@(negedge ref_clk_in);
			chk("dn rst", dnr, 4'h0);
			chk("core rst", crst, 4'h0);
			cyc(1);
			frst <= 1'b1;
			pd <= i[0];
			cyc(8);
			@(negedge ref_clk_in);
			chk("fanout en", en, i[0]);
			chk("fanout gate", rop, {3{i[0]}});
			chk("dn idle", dnr, 4'h3);
		end
		for (i = 0; i < 2; i++) begin
			cyc(1);
			pres[i] <= 1'b0;
			hold_chk(4'h3 ^ (4'h1 << i));
		end
		// Cards seated when fundamental reset ends get one unbroken hold
		cyc(1);
		frst <= 1'b0;
		pd <= 1'b0;
		cyc(4);
		frst <= 1'b1;
		hold_chk(4'h0);
		chk("strap kept", en, 4'h1);
		for (i = 0; i < 200; i++) begin
			cyc(1);
			// First pass drives all zeros, the second all ones, then random values
			r = (i < 2) ? {32{i[0]}} : $random(seed);
			ld <= r[3:0];
			utx <= r[5:4];
			dtx <= r[7:6];
			rin <= r[8];
			cyc(5);
			@(negedge ref_clk_in);
			chk("rx map", {drx, urx}, rxmap(rxp));
			chk("rx neg", {drn, urn}, rxmap(~rxp));
			chk("tx map", txp, txmap(utx, dtx));
			chk("tx neg", txn, txmap(~utx, ~dtx));
			chk("fanout", rop, {3{rin}});
			chk("fanout neg", ron, {3{~rin}});
		end
		stop_test;
	end
endmodule
`default_nettype wire
